// ### scaler_pkg.sv
// Constants, types and register map of the fixed-point scaler
package scaler_pkg;
   localparam int IN_W       = 32;
   localparam int IN_FRAC    = 24;
   localparam int OUT_TYPE_W = 16;
   localparam int OUT_FRAC   = 15;
   localparam int CH_W       = 4;
   localparam int SH_W       = 5;
   localparam int NUM_SH     = 4;
   localparam int IDX_W      = 2;
   localparam int LATENCY    = 2;
   localparam int DROP       = IN_FRAC - OUT_FRAC;
   localparam int SH_BIAS    = 1 << (SH_W - 1);
   localparam int EXT_W      = IN_W + 2 * SH_BIAS - 1;
   localparam int RND_POS    = DROP + SH_BIAS;
   localparam int KW         = EXT_W - RND_POS + 1;
   // Never wider than what the largest gain can fill
   localparam int OUT_W      = (OUT_TYPE_W < KW - 1) ? OUT_TYPE_W : KW - 1;

   localparam logic signed [KW-1:0] LIM_S_MAX   = {{(KW-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
   localparam logic signed [KW-1:0] LIM_S_MIN   = {{(KW-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}};
   localparam logic signed [KW-1:0] LIM_S_SYM   = {{(KW-OUT_W+1){1'b1}}, {(OUT_W-2){1'b0}}, 1'b1};
   localparam logic signed [KW-1:0] LIM_U_MAX   = {{(KW-OUT_W){1'b0}}, {OUT_W{1'b1}}};
   localparam logic signed [KW-1:0] LIM_U_MIN   = '0;
   localparam logic [OUT_W-1:0]     Q_SMAX      = {1'b0, {(OUT_W-1){1'b1}}};
   localparam logic [OUT_W-1:0]     Q_SMIN      = {1'b1, {(OUT_W-1){1'b0}}};

   localparam int        AW            = 8;
   localparam logic [AW-1:0] ADDR_CTRL    = 8'h00;
   localparam logic [AW-1:0] ADDR_SHIFT0  = 8'h04;
   localparam logic [AW-1:0] SHIFT_SPAN   = 8'h10;
   localparam logic [AW-1:0] ADDR_STATUS  = 8'h14;
   localparam logic [AW-1:0] ADDR_INT_EN  = 8'h18;
   localparam logic [AW-1:0] ADDR_INT_CLR = 8'h1C;
   localparam logic [AW-1:0] ADDR_COUNT   = 8'h20;
   localparam int        CTRL_RND_LSB  = 0;
   localparam int        CTRL_SAT_LSB  = 2;
   localparam int        CTRL_SIGN_BIT = 4;
   localparam int        CTRL_W        = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h10;
   localparam logic [SH_W-1:0]   SHIFT_RST = 5'h00;
   localparam int        EV_CLIP       = 0;
   localparam int        EV_WRAP       = 1;
   localparam int        EV_W          = 2;

   typedef enum logic [1:0] {RND_TRUNC, RND_HALF_UP, RND_HALF_EVEN} round_t;
   typedef enum logic [1:0] {SAT_NONE, SAT_ASYM, SAT_SYM} sat_t;

   typedef struct packed {
      logic   is_signed;
      sat_t   sat;
      round_t rnd;
   } cfg_t;

   typedef struct packed {
      logic            valid;
      logic [CH_W-1:0] chan;
      logic [IN_W-1:0] data;
   } sample_t;

   typedef struct packed {
      logic             valid;
      logic [CH_W-1:0]  chan;
      logic [OUT_W-1:0] data;
      logic             exc;
      logic             wrap;
   } result_t;
endpackage

// ### scale_core.sv
// Two-stage shift, round and saturate datapath
`timescale 1ns/100ps
module scale_core (
   input  wire logic            clk_sys,
   input  wire logic            resetn,
   input  scaler_pkg::sample_t  in_s,
   input  wire logic [4:0]      shift_amt,
   input  scaler_pkg::cfg_t     cfg,
   output scaler_pkg::result_t  out_r
);
   import scaler_pkg::*;

   logic signed [EXT_W-1:0] ext;
   logic signed [EXT_W-1:0] shl;
   logic [SH_W-1:0]         amt;
   logic signed [KW-1:0]    kept;
   logic signed [KW-1:0]    nxt_rnd;
   logic                    half;
   logic                    rest;
   logic                    inc;
   logic signed [KW-1:0]    rnd_ff;
   sample_t                 s1_ff;
   cfg_t                    cfg1_ff;
   logic signed [KW-1:0]    hi;
   logic signed [KW-1:0]    lo_full;
   logic signed [KW-1:0]    lo;
   result_t                 nxt_out;
   result_t                 out_ff;

   // Biased count keeps every shift a left shift into a fixed rounding point
   always_comb begin
      amt  = {~shift_amt[SH_W-1], shift_amt[SH_W-2:0]};
      ext  = {{(EXT_W-IN_W){in_s.data[IN_W-1] & cfg.is_signed}}, in_s.data};
      shl  = ext <<< amt;
      // Top bit of an unsigned word at full gain is data, not sign
      kept = {shl[EXT_W-1] & cfg.is_signed, shl[EXT_W-1:RND_POS]};
      half = shl[RND_POS-1];
      rest = |shl[RND_POS-2:0];
      unique case (cfg.rnd)
         RND_HALF_UP:   inc = half;
         RND_HALF_EVEN: inc = half & (rest | kept[0]);
         default:       inc = 1'b0;
      endcase
      nxt_rnd = kept + {{(KW-1){1'b0}}, inc};
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rnd_ff  <= '0;
         s1_ff   <= '0;
         cfg1_ff <= '0;
      end else begin
         rnd_ff  <= nxt_rnd;
         s1_ff   <= in_s;
         cfg1_ff <= cfg;
      end
   end

   always_comb begin
      hi      = cfg1_ff.is_signed ? LIM_S_MAX : LIM_U_MAX;
      lo_full = cfg1_ff.is_signed ? LIM_S_MIN : LIM_U_MIN;
      lo      = (cfg1_ff.is_signed && cfg1_ff.sat == SAT_SYM) ? LIM_S_SYM : lo_full;
      nxt_out       = '0;
      nxt_out.valid = s1_ff.valid;
      nxt_out.chan  = s1_ff.chan;
      nxt_out.data  = rnd_ff[OUT_W-1:0];
      unique case (cfg1_ff.sat)
         SAT_ASYM: begin
            nxt_out.exc = (rnd_ff > hi) || (rnd_ff < lo_full);
            if (rnd_ff > hi) nxt_out.data = hi[OUT_W-1:0];
            if (rnd_ff < lo_full) nxt_out.data = lo_full[OUT_W-1:0];
         end
         SAT_SYM: begin
            nxt_out.exc = (rnd_ff > hi) || (rnd_ff < lo);
            if (rnd_ff > hi) nxt_out.data = hi[OUT_W-1:0];
            if (rnd_ff < lo) nxt_out.data = lo[OUT_W-1:0];
         end
         default: begin
            nxt_out.exc  = (rnd_ff > hi) || (rnd_ff < lo_full);
            nxt_out.wrap = nxt_out.exc;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         out_ff <= '0;
      end else begin
         out_ff <= nxt_out;
      end
   end

   assign out_r = out_ff;
endmodule // scale_core

// ### scaler_top.sv
// Fixed-point scaler with APB registers and interrupt
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
module scaler_top (
   input  wire logic                   clk_sys,
   input  wire logic                   resetn,
   input  wire logic [7:0]             paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  scaler_pkg::sample_t         a_in,
   input  wire logic [1:0]             shift_sel,
   output scaler_pkg::result_t         q_out,
   output logic                        irq
);
   import scaler_pkg::*;

   logic [CTRL_W-1:0] ctrl_ff;
   logic [SH_W-1:0]   shift_ff [NUM_SH];
   logic [EV_W-1:0]   status_ff;
   logic [EV_W-1:0]   int_en_ff;
   logic [31:0]       count_ff;
   logic [31:0]       prdata_ff;
   logic              err_ff;
   logic              irq_ff;
   logic              setup;
   logic              wr_en;
   logic [AW-1:0]     sh_off;
   logic [IDX_W-1:0]  sh_idx;
   logic              sh_hit;
   logic [31:0]       rd_word;
   logic              rd_hit;
   logic [EV_W-1:0]   ev;
   logic [EV_W-1:0]   clr_mask;
   logic [SH_W-1:0]   sel_shift;
   cfg_t              cfg;

   // Zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign setup   = psel & ~penable;
   assign wr_en   = psel & penable & pwrite;
   assign sh_off  = paddr - ADDR_SHIFT0;
   assign sh_idx  = sh_off[IDX_W+1:2];
   assign sh_hit  = (sh_off < SHIFT_SPAN) && (paddr[1:0] == 2'h0);

   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      if (sh_hit) begin
         rd_word[SH_W-1:0] = shift_ff[sh_idx];
      end else begin
         unique case (paddr)
            ADDR_CTRL:    rd_word[CTRL_W-1:0] = ctrl_ff;
            ADDR_STATUS:  rd_word[EV_W-1:0]   = status_ff;
            ADDR_INT_EN:  rd_word[EV_W-1:0]   = int_en_ff;
            ADDR_INT_CLR: rd_word             = '0;
            ADDR_COUNT:   rd_word             = count_ff;
            default:      rd_hit              = 1'b0;
         endcase
      end
   end

   // Read data latched in setup so it comes from a flop in the access cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata_ff <= '0;
         err_ff    <= 1'b0;
      end else if (setup) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
         err_ff    <= ~rd_hit;
      end
   end

   assign prdata  = prdata_ff;
   assign pslverr = err_ff;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_en && !err_ff && paddr == ADDR_CTRL) begin
         ctrl_ff <= pwdata[CTRL_W-1:0];
      end
   end

   for (genvar i = 0; i < NUM_SH; i++) begin : g_shift
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            shift_ff[i] <= SHIFT_RST;
         end else if (wr_en && sh_hit && sh_idx == IDX_W'(i)) begin
            shift_ff[i] <= pwdata[SH_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         int_en_ff <= '0;
      end else if (wr_en && paddr == ADDR_INT_EN) begin
         int_en_ff <= pwdata[EV_W-1:0];
      end
   end

   // Table entry picked every cycle by the upstream index
   assign sel_shift = shift_ff[shift_sel];
   assign cfg.is_signed = ctrl_ff[CTRL_SIGN_BIT];
   assign cfg.sat       = sat_t'(ctrl_ff[CTRL_SAT_LSB +: 2]);
   assign cfg.rnd       = round_t'(ctrl_ff[CTRL_RND_LSB +: 2]);

   // Relies on upstream keeping valid and channel honest
   scale_core u_core (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .in_s      (a_in),
      .shift_amt (sel_shift),
      .cfg       (cfg),
      .out_r     (q_out)
   );

   assign ev[EV_CLIP] = q_out.valid & q_out.exc & ~q_out.wrap;
   assign ev[EV_WRAP] = q_out.valid & q_out.wrap;
   assign clr_mask    = (wr_en && paddr == ADDR_INT_CLR) ? pwdata[EV_W-1:0] : '0;

   // Set beats clear so an event in the clearing cycle is kept
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         status_ff <= '0;
      end else begin
         status_ff <= (status_ff & ~clr_mask) | ev;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count_ff <= '0;
      end else if (q_out.valid) begin
         count_ff <= count_ff + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(status_ff & int_en_ff);
      end
   end

   assign irq = irq_ff;

   // Checking helpers, conditions as seen at input time
   logic pass_cfg;
   logic sgn_cfg;
   assign pass_cfg = cfg.is_signed && cfg.sat == SAT_NONE;
   assign sgn_cfg  = a_in.valid && cfg.is_signed;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence in_burst;
      a_in.valid [*3];
   endsequence

   sequence out_burst;
      q_out.valid [*3];
   endsequence

   chk_valid_delay: assert property (
      q_out.valid == $past(a_in.valid, 2))
      else $error("output valid not aligned with input valid");

   chk_chan_delay: assert property (
      q_out.valid |-> q_out.chan == $past(a_in.chan, 2))
      else $error("output channel does not match its sample");

   chk_every_cycle: assert property (
      in_burst |-> out_burst)
      else $error("back to back samples not all passed");

   chk_none_pass: assert property (
      $past(a_in.valid && pass_cfg && cfg.rnd == RND_TRUNC && sel_shift == 5'h00, 2)
      |-> q_out.data == $past(a_in.data[DROP+OUT_W-1:DROP], 2))
      else $error("unclipped pass through wrong");

   chk_shift_pick: assert property (
      $past(a_in.valid && pass_cfg && cfg.rnd == RND_TRUNC && shift_sel == 2'h1 && shift_ff[1] == 5'h01, 2)
      |-> q_out.data == $past(a_in.data[DROP+OUT_W-2:DROP-1], 2))
      else $error("gain from indexed entry wrong");

   chk_attenuate: assert property (
      $past(a_in.valid && cfg.sat == SAT_NONE && cfg.rnd == RND_TRUNC && sel_shift == 5'h10, 2)
      |-> q_out.data == {{(OUT_W-IN_W+RND_POS){$past(a_in.data[IN_W-1] & cfg.is_signed, 2)}},
                         $past(a_in.data[IN_W-1:RND_POS], 2)})
      else $error("attenuation fill wrong");

   chk_round_up: assert property (
      $past(a_in.valid && pass_cfg && cfg.rnd == RND_HALF_UP && sel_shift == 5'h00, 2)
      |-> q_out.data == $past(a_in.data[DROP+OUT_W-1:DROP] + {{(OUT_W-1){1'b0}}, a_in.data[DROP-1]}, 2))
      else $error("round half up wrong");

   chk_round_even: assert property (
      $past(a_in.valid && pass_cfg && cfg.rnd == RND_HALF_EVEN && sel_shift == 5'h00, 2)
      |-> q_out.data == $past(a_in.data[DROP+OUT_W-1:DROP] + {{(OUT_W-1){1'b0}},
          a_in.data[DROP-1] & ((|a_in.data[DROP-2:0]) | a_in.data[DROP])}, 2))
      else $error("round half even wrong");

   chk_asym_clip: assert property (
      $past(sgn_cfg && cfg.sat == SAT_ASYM, 2) && q_out.exc
      |-> q_out.data == Q_SMAX || q_out.data == Q_SMIN)
      else $error("asymmetric clip value wrong");

   chk_sym_bound: assert property (
      $past(sgn_cfg && cfg.sat == SAT_SYM, 2) |-> q_out.data != Q_SMIN)
      else $error("symmetric mode gave most negative code");

   chk_exc_status: assert property (
      (q_out.valid && q_out.exc) |=> status_ff != '0)
      else $error("exception not recorded in status");

   chk_irq_follow: assert property (
      (status_ff & int_en_ff) != '0 |=> irq)
      else $error("interrupt not raised");

   // Event flags follow the output word one edge later
   sequence clip_out;
      q_out.valid && q_out.exc && !q_out.wrap;
   endsequence

   sequence wrap_out;
      q_out.valid && q_out.wrap;
   endsequence

   chk_clip_set: assert property (
      clip_out |=> status_ff[EV_CLIP])
      else $error("clip event not recorded");

   chk_wrap_set: assert property (
      wrap_out |=> status_ff[EV_WRAP])
      else $error("wrap event not recorded");

   chk_wrap_exc: assert property (
      q_out.wrap |-> q_out.exc)
      else $error("wrap without exception flag");

   chk_wrap_mode: assert property (
      q_out.wrap |-> $past(cfg.sat != SAT_ASYM && cfg.sat != SAT_SYM, 2))
      else $error("wrap flagged in a saturating mode");

   chk_sym_clip: assert property (
      $past(sgn_cfg && cfg.sat == SAT_SYM, 2) && q_out.exc
      |-> q_out.data == Q_SMAX || q_out.data == {Q_SMIN[OUT_W-1:1], 1'b1})
      else $error("symmetric clip value wrong");

   chk_uns_clip: assert property (
      $past(a_in.valid && !cfg.is_signed && cfg.sat == SAT_ASYM, 2) && q_out.exc
      |-> q_out.data == {OUT_W{1'b1}} || q_out.data == {OUT_W{1'b0}})
      else $error("unsigned clip value wrong");

   chk_reset_out: assert property (
      $rose(resetn) |-> !q_out.valid && !q_out.exc)
      else $error("output flags not cleared by reset");

   // Sticky flags: only a clear without a new event drops them
   chk_clip_keep: assert property (
      status_ff[EV_CLIP] && !clr_mask[EV_CLIP] |=> status_ff[EV_CLIP])
      else $error("clip flag lost without clear");

   chk_clip_clear: assert property (
      clr_mask[EV_CLIP] && !ev[EV_CLIP] |=> !status_ff[EV_CLIP])
      else $error("clip flag not cleared");

   chk_status_ro: assert property (
      wr_en && paddr == ADDR_STATUS && ev == '0 |=> $stable(status_ff))
      else $error("status register took a write");

   chk_count_step: assert property (
      q_out.valid |=> count_ff == $past(count_ff) + 32'h0000_0001)
      else $error("sample count did not advance");

   chk_count_hold: assert property (
      !q_out.valid |=> $stable(count_ff))
      else $error("sample count moved while idle");

   chk_bad_addr: assert property (
      setup && !rd_hit |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   chk_good_addr: assert property (
      setup && rd_hit |=> !pslverr)
      else $error("mapped access flagged as error");

   chk_ctrl_write: assert property (
      wr_en && paddr == ADDR_CTRL |=> ctrl_ff == $past(pwdata[CTRL_W-1:0]))
      else $error("control write lost");

   chk_en_write: assert property (
      wr_en && paddr == ADDR_INT_EN |=> int_en_ff == $past(pwdata[EV_W-1:0]))
      else $error("interrupt enable write lost");

   chk_irq_masked: assert property (
      (status_ff & int_en_ff) == '0 |=> !irq)
      else $error("interrupt raised while masked");
endmodule // scaler_top

// ### stream_source.sv
// Upstream sample source model for the scaler stream
`timescale 1ns/100ps
module stream_source (
   output scaler_pkg::sample_t a_in,
   output logic [1:0]          shift_sel
);
   import scaler_pkg::*;
   initial begin
      a_in      = '0;
      shift_sel = 2'h0;
   end
   // Caller steps just after a rising edge
   task automatic put(input logic [CH_W-1:0] ch, input logic [IN_W-1:0] d, input logic [1:0] sel);
      a_in.valid <= 1'b1;
      a_in.chan  <= ch;
      a_in.data  <= d;
      shift_sel  <= sel;
   endtask
   // Idle words carry junk so nothing leans on stale data
   task automatic rest();
      a_in.valid <= 1'b0;
      a_in.chan  <= ~a_in.chan;
      a_in.data  <= ~a_in.data;
   endtask
endmodule // stream_source

// ### test_fixed_point_scaler.sv
// Self-checking testbench of the fixed-point scaler
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_fixed_point_scaler;
   import scaler_pkg::*;
   logic        clk_sys   = 1'b0;
   logic        resetn    = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [31:0] pwdata    = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   sample_t     a_in;
   logic [1:0]  shift_sel;
   result_t     q_out;
   result_t     exp_in    = '0;
   result_t     e1;
   result_t     e2;
   logic        exp_chk   = 1'b0;
   logic        c1;
   logic        c2;
   logic [31:0] n_valid   = 32'h0;
   logic [31:0] rd_d;
   logic        rd_e;
   int          err_total = 0;
   int          n_tests   = 0;
   logic [31:0] sat_x [3] = '{32'h0100_0000, 32'hFF00_0000, 32'hFE00_0000};
   logic [17:0] sat_tab [4][3] = '{
      '{{16'h8000, 2'b11}, {16'h8000, 2'b00}, {16'h0000, 2'b11}},
      '{{16'h7FFF, 2'b10}, {16'h8000, 2'b00}, {16'h8000, 2'b10}},
      '{{16'h7FFF, 2'b10}, {16'h8001, 2'b10}, {16'h8001, 2'b10}},
      '{{16'h8000, 2'b11}, {16'h8000, 2'b00}, {16'h0000, 2'b11}}};
   logic [31:0] rnd_x [3] = '{32'h0000_0100, 32'h0000_0300, 32'hFFFF_FF00};
   logic [15:0] rnd_tab [4][3] = '{'{16'h0000, 16'h0001, 16'hFFFF}, '{16'h0001, 16'h0002, 16'h0000},
                                   '{16'h0000, 16'h0002, 16'h0000}, '{16'h0000, 16'h0001, 16'hFFFF}};
   logic [15:0] gain_q [4] = '{16'h1000, 16'h2000, 16'h0800, 16'h4000};

   always #5 clk_sys = ~clk_sys;

   scaler_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
                     .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                     .a_in(a_in), .shift_sel(shift_sel), .q_out(q_out), .irq(irq));
   stream_source i_src (.a_in(a_in), .shift_sel(shift_sel));

   // Expectations ride a two-deep line to match the latency
   always @(posedge clk_sys) begin
      if (!resetn) begin
         c1 <= 1'b0;
         c2 <= 1'b0;
      end else begin
         e1 <= exp_in;
         c1 <= exp_chk;
         e2 <= e1;
         c2 <= c1;
      end
   end

   // Falling edge keeps the compare clear of update races
   always @(negedge clk_sys) begin
      if (!resetn) begin
         `CHK("reset valid", 1'b0, q_out.valid)
         `CHK("reset exc", 1'b0, q_out.exc)
      end else if (c2) begin
         `CHK("q_out", e2, q_out)
      end else begin
         `CHK("idle valid", 1'b0, q_out.valid)
      end
   end

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd_d = prdata;
      rd_e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic ee);
      xfer(a, 1'b0, 32'h0);
      `CHK("prdata", ex, rd_d)
      `CHK("pslverr", ee, rd_e)
   endtask

   task automatic smp(input logic [3:0] ch, input logic [31:0] x, input logic [1:0] sel,
                      input logic [15:0] q, input logic e, input logic w);
      @(posedge clk_sys);
      i_src.put(ch, x, sel);
      exp_in  <= '{valid: 1'b1, chan: ch, data: q, exc: e, wrap: w};
      exp_chk <= 1'b1;
      n_valid++;
   endtask

   task automatic rest();
      @(posedge clk_sys);
      i_src.rest();
      exp_chk <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(ADDR_CTRL, 32'h10, 1'b0);
      for (int i = 0; i < 4; i++) rd(ADDR_SHIFT0 + 8'(4 * i), 32'h0, 1'b0);
      rd(ADDR_STATUS, 32'h0, 1'b0);
      rd(ADDR_INT_EN, 32'h0, 1'b0);
      rd(ADDR_COUNT, 32'h0, 1'b0);
      rd(8'h24, 32'h0, 1'b1);
      wr(ADDR_STATUS, 32'hFFFF_FFFF);
      rd(ADDR_STATUS, 32'h0, 1'b0);
      wr(ADDR_SHIFT0 + 8'h04, 32'h01);
      wr(ADDR_SHIFT0 + 8'h08, 32'h1F);
      wr(ADDR_SHIFT0 + 8'h0C, 32'hFFFF_FFE2);
      rd(ADDR_SHIFT0 + 8'h0C, 32'h02, 1'b0);
      for (int i = 0; i < 4; i++) smp(4'(i), 32'h0020_0000, 2'(i), gain_q[i], 1'b0, 1'b0);
      smp(4'h4, 32'hFF00_0000, 2'h2, 16'hC000, 1'b0, 1'b0);
      rest();
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_CTRL, 32'h10 | 32'(m << 2));
         for (int k = 0; k < 3; k++) smp(4'(k), sat_x[k], 2'h0, sat_tab[m][k][17:2], sat_tab[m][k][1], sat_tab[m][k][0]);
         rest();
      end
      rd(ADDR_STATUS, 32'h3, 1'b0);
      `CHK("irq masked", 1'b0, irq)
      wr(ADDR_INT_EN, 32'h1);
      rd(ADDR_INT_EN, 32'h1, 1'b0);
      `CHK("irq on", 1'b1, irq)
      wr(ADDR_INT_CLR, 32'h1);
      rd(ADDR_STATUS, 32'h2, 1'b0);
      `CHK("irq cleared", 1'b0, irq)
      wr(ADDR_INT_EN, 32'h2);
      rd(ADDR_INT_CLR, 32'h0, 1'b0);
      `CHK("irq on", 1'b1, irq)
      wr(ADDR_INT_CLR, 32'h3);
      rd(ADDR_STATUS, 32'h0, 1'b0);
      `CHK("irq cleared", 1'b0, irq)
      for (int r = 0; r < 4; r++) begin
         wr(ADDR_CTRL, 32'h10 | 32'(r));
         for (int k = 0; k < 3; k++) smp(4'(k), rnd_x[k], 2'h0, rnd_tab[r][k], 1'b0, 1'b0);
         rest();
      end
      wr(ADDR_SHIFT0, 32'h10);
      wr(ADDR_CTRL, 32'h00);
      smp(4'h5, 32'h8000_0000, 2'h0, 16'h0040, 1'b0, 1'b0);
      rest();
      wr(ADDR_CTRL, 32'h10);
      smp(4'h5, 32'h8000_0000, 2'h0, 16'hFFC0, 1'b0, 1'b0);
      rest();
      wr(ADDR_SHIFT0, 32'h00);
      wr(ADDR_CTRL, 32'h04);
      smp(4'h6, 32'h8000_0000, 2'h0, 16'hFFFF, 1'b1, 1'b0);
      rest();
      repeat (4) @(posedge clk_sys);
      rd(ADDR_COUNT, n_valid, 1'b0);
      // Reset lands with samples still in flight
      smp(4'h7, 32'h0020_0000, 2'h0, 16'h1000, 1'b0, 1'b0);
      smp(4'h7, 32'h0020_0000, 2'h0, 16'h1000, 1'b0, 1'b0);
      rest();
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(ADDR_CTRL, 32'h10, 1'b0);
      give_verdict();
   end
endmodule // test_fixed_point_scaler
